/* File: rtl/jbt_tap_defs.vh */
`ifndef JBT_TAP_DEFS_VH
`define JBT_TAP_DEFS_VH
// TAP states, one-hot, sixteen of them
`define JBT_ST_RESET   16'h0001
`define JBT_ST_IDLE    16'h0002
`define JBT_ST_SELDR   16'h0004
`define JBT_ST_CAPDR   16'h0008
`define JBT_ST_SHDR    16'h0010
`define JBT_ST_EX1DR   16'h0020
`define JBT_ST_PAUSEDR 16'h0040
`define JBT_ST_EX2DR   16'h0080
`define JBT_ST_UPDDR   16'h0100
`define JBT_ST_SELIR   16'h0200
`define JBT_ST_CAPIR   16'h0400
`define JBT_ST_SHIR    16'h0800
`define JBT_ST_EX1IR   16'h1000
`define JBT_ST_PAUSEIR 16'h2000
`define JBT_ST_EX2IR   16'h4000
`define JBT_ST_UPDIR   16'h8000
// Instruction codes, 4-bit register
`define JBT_IR_EXTEST  4'h0
`define JBT_IR_SAMPLE  4'h1
`define JBT_IR_IDCODE  4'he
`define JBT_IR_BYPASS  4'hf
`define JBT_IR_CAPVAL  4'h1
// Cells per I/O: input, output, enable
`define JBT_CELLS      3
`define JBT_CELL_IN    0
`define JBT_CELL_OUT   1
`define JBT_CELL_OE    2
// Undriven TMS and TDI read as ones
`define JBT_PIN_IDLE   2'h3
`endif

/* File: rtl/jbt_tap.v */
`timescale 1ns/1ps
`include "jbt_tap_defs.vh"
module jbt_tap #(
    parameter        NUM_IO   = 4,           // User I/O count
    parameter [3:0]  VERSION  = 4'h0,        // Arbitrary value
    parameter [15:0] PART_NUM = 16'h0001,    // Arbitrary value
    parameter [10:0] MAKER_ID = 11'h001      // Arbitrary value
) (
    input  wire              clk,            // 20 MHz system clock
    input  wire              rst,            // Async reset, power-up
    input  wire              tck,            // Test clock pin
    input  wire              tms,            // Mode select pin, pulled up outside
    input  wire              tdi,            // Test data in, pulled up outside
    input  wire              trstN,          // Test reset, active low
    input  wire              configured,     // Device holds a configuration
    input  wire [NUM_IO-1:0] padIn,          // Pad input levels
    input  wire [NUM_IO-1:0] coreOut,        // Core output data
    input  wire [NUM_IO-1:0] coreOe,         // Core output enables
    output reg  [NUM_IO-1:0] padOut,         // Pad output data
    output reg  [NUM_IO-1:0] padOe,          // Pad output enables
    output reg  [NUM_IO-1:0] coreIn,         // Pad data toward core
    output reg               ioEnable,       // Global I/O enable
    output reg               tdo,            // Test data out
    output reg               tdoOe           // TDO drive enable
);
    localparam CHAIN = NUM_IO * `JBT_CELLS;

    // Synchronisers for the test pins and the pads
    reg [1:0] tckS_q, tmsS_q, tdiS_q, trstS_q;
    reg       tckOld_q;
    reg [NUM_IO-1:0] padS1_q, padS2_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tckS_q   <= 2'h0;
            tmsS_q   <= `JBT_PIN_IDLE;
            tdiS_q   <= `JBT_PIN_IDLE;
            tckOld_q <= 1'b0;
            padS1_q  <= {NUM_IO{1'b0}};
            padS2_q  <= {NUM_IO{1'b0}};
        end else begin
            tckS_q   <= {tckS_q[0], tck};
            tmsS_q   <= {tmsS_q[0], tms};
            tdiS_q   <= {tdiS_q[0], tdi};
            tckOld_q <= tckS_q[1];
            padS1_q  <= padIn;
            padS2_q  <= padS1_q;
        end
    end

    // Edge strobes last one clk; TCK phases must each span two clk
    wire tckRise = tckS_q[1] & ~tckOld_q;
    wire tckFall = ~tckS_q[1] & tckOld_q;
    wire tmsV    = tmsS_q[1];
    wire tdiV    = tdiS_q[1];
    // TRST clears its pair at once; release is retimed to clk so the
    // TAP registers never leave reset close to an edge
    wire trstClr = rst | ~trstN;
    always @(posedge clk or posedge trstClr) begin
        if (trstClr) begin
            trstS_q <= 2'h0;
        end else begin
            trstS_q <= {trstS_q[0], 1'b1};
        end
    end

    // Test logic reset: power-up or TRST, neither waits for TCK
    wire tapClr = rst | ~trstS_q[1];

    // Next-state of the sixteen-state controller
    reg [15:0] st_q, st_d;
    always @* begin
        case (st_q)
            `JBT_ST_RESET:   st_d = tmsV ? `JBT_ST_RESET : `JBT_ST_IDLE;
            `JBT_ST_IDLE:    st_d = tmsV ? `JBT_ST_SELDR : `JBT_ST_IDLE;
            `JBT_ST_SELDR:   st_d = tmsV ? `JBT_ST_SELIR : `JBT_ST_CAPDR;
            `JBT_ST_CAPDR:   st_d = tmsV ? `JBT_ST_EX1DR : `JBT_ST_SHDR;
            `JBT_ST_SHDR:    st_d = tmsV ? `JBT_ST_EX1DR : `JBT_ST_SHDR;
            `JBT_ST_EX1DR:   st_d = tmsV ? `JBT_ST_UPDDR : `JBT_ST_PAUSEDR;
            `JBT_ST_PAUSEDR: st_d = tmsV ? `JBT_ST_EX2DR : `JBT_ST_PAUSEDR;
            `JBT_ST_EX2DR:   st_d = tmsV ? `JBT_ST_UPDDR : `JBT_ST_SHDR;
            `JBT_ST_UPDDR:   st_d = tmsV ? `JBT_ST_SELDR : `JBT_ST_IDLE;
            `JBT_ST_SELIR:   st_d = tmsV ? `JBT_ST_RESET : `JBT_ST_CAPIR;
            `JBT_ST_CAPIR:   st_d = tmsV ? `JBT_ST_EX1IR : `JBT_ST_SHIR;
            `JBT_ST_SHIR:    st_d = tmsV ? `JBT_ST_EX1IR : `JBT_ST_SHIR;
            `JBT_ST_EX1IR:   st_d = tmsV ? `JBT_ST_UPDIR : `JBT_ST_PAUSEIR;
            `JBT_ST_PAUSEIR: st_d = tmsV ? `JBT_ST_EX2IR : `JBT_ST_PAUSEIR;
            `JBT_ST_EX2IR:   st_d = tmsV ? `JBT_ST_UPDIR : `JBT_ST_SHIR;
            `JBT_ST_UPDIR:   st_d = tmsV ? `JBT_ST_SELDR : `JBT_ST_IDLE;
            // Any code outside the sixteen falls back to reset
            default:         st_d = `JBT_ST_RESET;
        endcase
    end

    // Decoding shared by capture, shift and update paths
    function selBsr;
        input [3:0] ir;
        selBsr = (ir == `JBT_IR_EXTEST) | (ir == `JBT_IR_SAMPLE);
    endfunction

    // Shift stages, instruction and the data registers
    reg  [3:0]       irSh_q, ir_q;
    reg              byp_q;
    reg  [31:0]      idSh_q;
    reg  [CHAIN-1:0] bsSh_q, bsUpd_q;
    wire [31:0]      idVal = {VERSION, PART_NUM, MAKER_ID, 1'b1};
    wire             bsrSel = selBsr(ir_q);
    wire             idSel  = (ir_q == `JBT_IR_IDCODE);
    wire             extest = (ir_q == `JBT_IR_EXTEST);
    wire [CHAIN-1:0] bsCap;

    // Parallel-in per cell; pad capture needs enabled input buffers
    genvar g;
    generate
        for (g = 0; g < NUM_IO; g = g + 1) begin : gCell
            assign bsCap[g*`JBT_CELLS+`JBT_CELL_IN]  = padS2_q[g] & ioEnable;
            assign bsCap[g*`JBT_CELLS+`JBT_CELL_OUT] = coreOut[g];
            assign bsCap[g*`JBT_CELLS+`JBT_CELL_OE]  = coreOe[g];
        end
    endgenerate

    // TAP registers advance on sampled TCK rising edges
    always @(posedge clk or posedge tapClr) begin
        if (tapClr) begin
            st_q    <= `JBT_ST_RESET;
            irSh_q  <= 4'h0;
            ir_q    <= `JBT_IR_IDCODE;
            byp_q   <= 1'b0;
            idSh_q  <= 32'h0;
            bsSh_q  <= {CHAIN{1'b0}};
            bsUpd_q <= {CHAIN{1'b0}};
        end else if (tckRise) begin
            st_q <= st_d;
            // Capture and update act on the edge that leaves the state
            case (st_q)
                // IDCODE is the instruction after any reset
                `JBT_ST_RESET: ir_q <= `JBT_IR_IDCODE;
                `JBT_ST_CAPIR: irSh_q <= `JBT_IR_CAPVAL;
                `JBT_ST_SHIR:  irSh_q <= {tdiV, irSh_q[3:1]};
                `JBT_ST_UPDIR: ir_q <= irSh_q;
                `JBT_ST_CAPDR: begin
                    byp_q  <= 1'b0;
                    idSh_q <= idVal;
                    // Chain captures only when it is the selected path
                    if (bsrSel) begin
                        bsSh_q <= bsCap;
                    end
                end
                `JBT_ST_SHDR: begin
                    byp_q  <= tdiV;
                    idSh_q <= {tdiV, idSh_q[31:1]};
                    if (bsrSel) begin
                        bsSh_q <= {tdiV, bsSh_q[CHAIN-1:1]};
                    end
                end
                `JBT_ST_UPDDR: begin
                    if (bsrSel) begin
                        bsUpd_q <= bsSh_q;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // TDO changes on the falling edge; unknown codes fall to bypass
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo   <= 1'b1;
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdoOe <= (st_q == `JBT_ST_SHDR) | (st_q == `JBT_ST_SHIR);
            if (st_q == `JBT_ST_SHIR) begin
                tdo <= irSh_q[0];
            end else if (bsrSel) begin
                tdo <= bsSh_q[0];
            end else if (idSel) begin
                tdo <= idSh_q[0];
            end else begin
                tdo <= byp_q;
            end
        end
    end

    // Pad muxing; whole I/O ring held off until configured
    integer i;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ioEnable <= 1'b0;
            padOut   <= {NUM_IO{1'b0}};
            padOe    <= {NUM_IO{1'b0}};
            coreIn   <= {NUM_IO{1'b0}};
        end else begin
            ioEnable <= configured;
            // padOut stays ungated; padOe alone keeps an unconfigured pin off
            for (i = 0; i < NUM_IO; i = i + 1) begin
                padOut[i] <= extest ? bsUpd_q[i*`JBT_CELLS+`JBT_CELL_OUT] : coreOut[i];
                padOe[i]  <= configured &
                             (extest ? bsUpd_q[i*`JBT_CELLS+`JBT_CELL_OE] : coreOe[i]);
                coreIn[i] <= configured & padS2_q[i];
            end
        end
    end
endmodule // jbt_tap

/* File: verif/jbt_tap_sva.sv */
`timescale 1ns/1ps
// Port checks on the scan block
module jbt_tap_sva #(parameter NUM_IO = 4) (
    input wire              clk,        // Clock
    input wire              rst,        // Reset
    input wire              tck,        // Test clock
    input wire              configured, // Config held
    input wire [NUM_IO-1:0] padOe,      // Pad enables
    input wire [NUM_IO-1:0] coreIn,     // To core
    input wire              ioEnable,   // Global enable
    input wire              tdo,        // Data out
    input wire              tdoOe       // Out enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_vals: assert property (disable iff (1'b0) $fell(rst) |-> tdo && !tdoOe && padOe == 0)
        else $error("Bad reset values");
    a_en_on: assert property (configured |=> ioEnable)
        else $error("Enable late");
    a_en_off: assert property (!configured |=> !ioEnable)
        else $error("Enable stuck");
    a_oe_off: assert property (!configured |=> padOe == 0)
        else $error("Pad driven");
    a_oe_needs_en: assert property (padOe != 0 |-> ioEnable)
        else $error("Pad on, enable off");
    a_in_blocked: assert property (!configured |=> coreIn == 0)
        else $error("Pad reached core");
    a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("Data out moved off a fall");
    a_oe_on_fall: assert property ($changed(tdoOe) |-> !$past(tck, 2))
        else $error("Out enable moved off a fall");
    c_shift: cover property ($rose(tdoOe));
    c_cfg: cover property ($rose(ioEnable));
    c_tdo: cover property ($fell(tdo));
endmodule // jbt_tap_sva
bind jbt_tap jbt_tap_sva #(.NUM_IO(NUM_IO)) i_sva (.clk(clk), .rst(rst), .tck(tck), .configured(configured),
    .padOe(padOe), .coreIn(coreIn), .ioEnable(ioEnable), .tdo(tdo), .tdoOe(tdoOe));

/* File: verif/jbt_tester.sv */
`timescale 1ns/1ps
// Tester model; TCK stands low between frames
module jbt_tester (
    output reg tck,   // Test clock
    output reg tms,   // Mode select
    output reg tdi,   // Test data
    output reg trstN, // Test reset
    input wire tdo    // Device data
);
    reg     o;
    integer k;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trstN = 1'b1;
    end
    // One period; data out read late in the high phase
    // Calls start just after a clk edge; 400 ns keeps that phase
    task tbit(input m, input d);
        begin
            tms = m;
            tdi = d;
            #195 tck = 1'b1;
            #190 o = tdo;
            #10 tck = 1'b0;
            #2 tdi = ~d; // Stale data is not kept
            #3;
        end
    endtask
    // Test reset held low for half a bit time
    task trst_pulse;
        begin
            trstN = 1'b0;
            #200 trstN = 1'b1;
        end
    endtask
    // Five ones reach reset from anywhere, then idle
    task to_idle;
        begin
            repeat (5) tbit(1'b1, 1'b1);
            tbit(1'b0, 1'b1);
        end
    endtask
    // Idle to idle scan, LSB first
    task shift(input ir, input integer n, input [31:0] din, output [31:0] dout);
        begin
            dout = 32'h0;
            tbit(1'b1, 1'b1);
            if (ir)
                tbit(1'b1, 1'b1);
            tbit(1'b0, 1'b1);
            tbit(1'b0, 1'b1);
            for (k = 0; k < n; k = k + 1) begin
                tbit(k == n - 1, din[k]);
                dout[k] = o;
            end
            tbit(1'b1, 1'b1);
            tbit(1'b0, 1'b1);
        end
    endtask
endmodule // jbt_tester

/* File: verif/tb_jbt_tap.sv */
`timescale 1ns/1ps
// Scan port driven through the tester model
module tb_jbt_tap;
    localparam [31:0] ID = {4'h3, 16'h00a5, 11'h02b, 1'b1}; // Arbitrary codes
    reg         clk = 1'b0;
    reg         rst = 1'b1;
    reg         cfg = 1'b0;
    reg [3:0]   padIn = 4'hf;
    reg [3:0]   coreOut = 4'h5;
    reg [3:0]   coreOe = 4'h3;
    wire        tck, tms, tdi, trstN, tdo, tdoOe, ioEnable;
    wire [3:0]  padOut, padOe, coreIn;
    reg [107:0] rows [0:3];
    reg [31:0]  got, din, ex, mk;
    reg [7:0]   len;
    reg [3:0]   ir;
    integer     miscompares = 0, n_checks = 0, cyc = 0, i;
    always #25 clk = ~clk;
    jbt_tap #(.VERSION(4'h3), .PART_NUM(16'h00a5), .MAKER_ID(11'h02b)) i_dut (.clk(clk), .rst(rst), .tck(tck),
        .tms(tms), .tdi(tdi), .trstN(trstN), .configured(cfg), .padIn(padIn), .coreOut(coreOut), .coreOe(coreOe),
        .padOut(padOut), .padOe(padOe), .coreIn(coreIn), .ioEnable(ioEnable), .tdo(tdo), .tdoOe(tdoOe));
    jbt_tester i_tester (.tck(tck), .tms(tms), .tdi(tdi), .trstN(trstN), .tdo(tdo));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("Checks %0d, mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // Load an instruction; capture pattern comes back
    task load_ir(input [3:0] code);
        begin
            i_tester.shift(1'b1, 4, {28'h0, code}, got);
            check(got & 32'hf, 32'h1);
        end
    endtask
    // From reset state to idle, then read the identity word
    task read_id;
        begin
            i_tester.tbit(1'b0, 1'b1);
            i_tester.shift(1'b0, 32, 32'h0, got);
            check(got, ID);
        end
    endtask
    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            miscompares = miscompares + 1;
            finish_test;
        end
    end
    initial begin
        rows[0] = {4'he, 8'h20, 32'h0, ID, 32'hffffffff};
        rows[1] = {4'hf, 8'h08, 32'hb5, 32'h6a, 32'hff};
        rows[2] = {4'h7, 8'h08, 32'hb5, 32'h6a, 32'hff};
        rows[3] = {4'h1, 8'h0c, 32'hfff, 32'h0, 32'h249};
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1 read_id;
        for (i = 0; i < 4; i = i + 1) begin
            {ir, len, din, ex, mk} = rows[i];
            load_ir(ir);
            i_tester.shift(1'b0, len, din, got);
            check(got & mk, ex);
            $display("Row %0d done", i);
        end
        // Configured: pads observed, then driven from the chain
        @(posedge clk) #1 cfg = 1'b1;
        i_tester.shift(1'b0, 12, 32'hd10, got);
        check(got & 32'h249, 32'h249);
        load_ir(4'h0);
        repeat (4) @(posedge clk);
        #1 check({24'h0, padOe, padOut}, 32'hca);
        check({27'h0, ioEnable, coreIn}, 32'h1f);
        @(posedge clk) #1 cfg = 1'b0;
        repeat (2) @(posedge clk);
        #1 check({28'h0, padOe}, 32'h0);
        check({27'h0, ioEnable, coreIn}, 32'h0);
        $display("Pad test done");
        // Each reset path returns the identity word
        load_ir(4'hf);
        i_tester.trst_pulse;
        read_id;
        load_ir(4'hf);
        @(posedge clk) #1 rst = 1'b1;
        @(posedge clk) #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        #1 read_id;
        load_ir(4'hf);
        i_tester.tbit(1'b1, 1'b1);
        i_tester.tbit(1'b0, 1'b1);
        i_tester.tbit(1'b0, 1'b1);
        i_tester.to_idle;
        read_id;
        $display("Reset test done");
        finish_test;
    end
endmodule // tb_jbt_tap
